// ==== shared/acc_defines.vh ====
// Constants for the converter clock and channel path control block
// What this block does
// - Word tagged 0101 is the clock word; tagged 0110 is the channel word.
// - Clock word bits 27 and 26 pick input converter clocks; 1 is external.
// - Bit 25 picks output converter clock, bit 24 logic clock; 1 external.
// - Input synthesizer divider code is bits 23..21, multiplier bits 20..12.
// - Output synthesizer divider code is bits 11..9, multiplier bits 8..0.
// - Divider codes 0..7 mean 1, 1.5, 2, 3, 4, 6, 8, 12.
// - Channel word: second decimation bits 24..20, first bits 16..12.
// - Factor 0 passes all; factor k drops one of each k+1 samples.
// - Channel word bit 8 enables the external trigger.
// - Channel word bit 9 sets trigger polarity; 1 is active high.
// - Source select bits 6..4 first, 2..0 second; 000 disables.
// - Select 001 sends a 16-bit counter on the channel clock.
// - Select 010 sends 14-bit samples sign-extended to 16 bits.
// - Select 011 sends samples with the top bit inverted.
// - Global reset word resets both words, the trigger latch, path counters and data; synchronizers and trigger level keep.
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH
`define ACC_TAG_MSB 31
`define ACC_TAG_LSB 28
`define ACC_TAG_CLOCK 4'h5
`define ACC_TAG_CHAN 4'h6
`define ACC_TAG_GRST 4'hd
`define ACC_REG_CLOCK 4'h5
`define ACC_REG_CHAN 4'h6
`define ACC_REG_STATUS 4'h8
`define ACC_CLOCK_RESET 32'h5f000000
`define ACC_CHAN_RESET 32'h60000000
`define ACC_CLK_SEL_A 27
`define ACC_CLK_SEL_B 26
`define ACC_CLK_SEL_DAC 25
`define ACC_CLK_SEL_LOGIC 24
`define ACC_ADC_N_MSB 23
`define ACC_ADC_N_LSB 21
`define ACC_ADC_M_MSB 20
`define ACC_ADC_M_LSB 12
`define ACC_DAC_N_MSB 11
`define ACC_DAC_N_LSB 9
`define ACC_DAC_M_MSB 8
`define ACC_DAC_M_LSB 0
`define ACC_DEC_B_LSB 20
`define ACC_DEC_A_LSB 12
`define ACC_TRIG_EN 8
`define ACC_TRIG_POL 9
`define ACC_SEL_A_LSB 4
`define ACC_SEL_B_LSB 0
`define ACC_SEL_OFF 3'h0
`define ACC_SEL_COUNT 3'h1
`define ACC_SEL_TWOS 3'h2
`define ACC_SEL_OFFBIN 3'h3
`endif

// ==== hdl/acc_path_ctrl.v ====
// Clock routing, synthesizer settings and converter channel path control
`timescale 1ns/1ps
`include "acc_defines.vh"
module acc_path_ctrl #(
  parameter SAMPLE_W = 14,
  parameter OUT_W = 16,
  parameter DEC_W = 5
) (
  input wire sys_clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg clk_sel_first_q,
  output reg clk_sel_second_q,
  output reg clk_sel_dac_q,
  output reg clk_sel_logic_q,
  output reg [2:0] adc_synth_n_q,
  output reg [8:0] adc_synth_m_q,
  output reg [4:0] adc_synth_div_x2_q,
  output reg [2:0] dac_synth_n_q,
  output reg [8:0] dac_synth_m_q,
  output reg [4:0] dac_synth_div_x2_q,
  input wire [1:0] conv_clk_pin,
  input wire [2*SAMPLE_W-1:0] conv_data_pin,
  input wire ext_trigger_pin,
  output reg [2*OUT_W-1:0] sample_bus_data_q,
  output reg [1:0] sample_bus_valid_q
);

  // Divide value times two, so that 1.5 stays an integer
  function [4:0] div_x2;
    input [2:0] code;
    begin
      case (code)
        3'h0: div_x2 = 5'h02;
        3'h1: div_x2 = 5'h03;
        3'h2: div_x2 = 5'h04;
        3'h3: div_x2 = 5'h06;
        3'h4: div_x2 = 5'h08;
        3'h5: div_x2 = 5'h0c;
        3'h6: div_x2 = 5'h10;
        default: div_x2 = 5'h18;
      endcase
    end
  endfunction

  reg [31:0] clock_word_q;
  reg [31:0] chan_word_q;
  reg soft_rst_q;
  reg trig_seen_q;
  reg [2:0] trig_sync_q;
  reg trig_lvl_q;
  wire [3:0] wr_tag;
  wire trig_active;
  wire [2:0] sel_vec [0:1];
  wire [DEC_W-1:0] dec_vec [0:1];

  assign wr_tag = reg_wdata[`ACC_TAG_MSB:`ACC_TAG_LSB];
  assign sel_vec[0] = chan_word_q[`ACC_SEL_A_LSB+2:`ACC_SEL_A_LSB];
  assign sel_vec[1] = chan_word_q[`ACC_SEL_B_LSB+2:`ACC_SEL_B_LSB];
  assign dec_vec[0] = chan_word_q[`ACC_DEC_A_LSB+DEC_W-1:`ACC_DEC_A_LSB];
  assign dec_vec[1] = chan_word_q[`ACC_DEC_B_LSB+DEC_W-1:`ACC_DEC_B_LSB];
  // Filtered level equals programmed polarity
  assign trig_active = (trig_lvl_q == chan_word_q[`ACC_TRIG_POL]);

  // Control words, decoded by their tag nibble whatever the address
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clock_word_q <= `ACC_CLOCK_RESET;
      chan_word_q <= `ACC_CHAN_RESET;
      soft_rst_q <= 1'b0;
    end else if (soft_rst_q) begin
      // One-cycle pulse clears both words, a write in that cycle is lost
      clock_word_q <= `ACC_CLOCK_RESET;
      chan_word_q <= `ACC_CHAN_RESET;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= reg_wr && (wr_tag == `ACC_TAG_GRST);
      if (reg_wr && wr_tag == `ACC_TAG_CLOCK) begin
        clock_word_q <= reg_wdata;
      end
      if (reg_wr && wr_tag == `ACC_TAG_CHAN) begin
        chan_word_q <= reg_wdata;
      end
    end
  end

  // Clock routing and synthesizer fields, registered straight out
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clk_sel_first_q <= 1'b1;
      clk_sel_second_q <= 1'b1;
      clk_sel_dac_q <= 1'b1;
      clk_sel_logic_q <= 1'b1;
      adc_synth_n_q <= 3'h0;
      adc_synth_m_q <= 9'h000;
      adc_synth_div_x2_q <= 5'h02;
      dac_synth_n_q <= 3'h0;
      dac_synth_m_q <= 9'h000;
      dac_synth_div_x2_q <= 5'h02;
    end else begin
      clk_sel_first_q <= clock_word_q[`ACC_CLK_SEL_A];
      clk_sel_second_q <= clock_word_q[`ACC_CLK_SEL_B];
      clk_sel_dac_q <= clock_word_q[`ACC_CLK_SEL_DAC];
      // Logic clock follows its own bit; host keeps it equal to bit 25
      clk_sel_logic_q <= clock_word_q[`ACC_CLK_SEL_LOGIC];
      adc_synth_n_q <= clock_word_q[`ACC_ADC_N_MSB:`ACC_ADC_N_LSB];
      adc_synth_m_q <= clock_word_q[`ACC_ADC_M_MSB:`ACC_ADC_M_LSB];
      adc_synth_div_x2_q <=
        div_x2(clock_word_q[`ACC_ADC_N_MSB:`ACC_ADC_N_LSB]);
      dac_synth_n_q <= clock_word_q[`ACC_DAC_N_MSB:`ACC_DAC_N_LSB];
      dac_synth_m_q <= clock_word_q[`ACC_DAC_M_MSB:`ACC_DAC_M_LSB];
      dac_synth_div_x2_q <=
        div_x2(clock_word_q[`ACC_DAC_N_MSB:`ACC_DAC_N_LSB]);
    end
  end

  // Trigger pin: three stages, level moves only when the last two agree
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      trig_sync_q <= 3'h0;
      trig_lvl_q <= 1'b0;
      trig_seen_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], ext_trigger_pin};
      if (trig_sync_q[1] == trig_sync_q[2]) begin
        trig_lvl_q <= trig_sync_q[2];
      end
      // Latched until the channel word is rewritten or reset
      if (soft_rst_q || (reg_wr && wr_tag == `ACC_TAG_CHAN)) begin
        trig_seen_q <= 1'b0;
      end else if (chan_word_q[`ACC_TRIG_EN] && trig_active) begin
        trig_seen_q <= 1'b1;
      end
    end
  end

  // Read port: stored words and a status word, data one cycle later
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ACC_REG_CLOCK: reg_rdata <= clock_word_q;
        `ACC_REG_CHAN: reg_rdata <= chan_word_q;
        `ACC_REG_STATUS: reg_rdata <= {29'h0, trig_lvl_q, trig_seen_q,
                                       trig_active};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // One sample path per converter
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      reg [2:0] clk_sync_q;
      reg clk_lvl_q;
      reg [SAMPLE_W-1:0] dat_s1_q;
      reg [SAMPLE_W-1:0] dat_s2_q;
      reg [SAMPLE_W-1:0] dat_s3_q;
      reg [OUT_W-1:0] count_q;
      reg [DEC_W-1:0] dec_cnt_q;
      reg [OUT_W-1:0] fmt;
      wire conv_edge;
      wire drop;
      wire gate_open;

      // Rising converter clock seen once the last two stages agree high
      assign conv_edge = clk_sync_q[1] & clk_sync_q[2] & ~clk_lvl_q;
      // Drop the last of each group of k+1 samples
      assign drop = (dec_vec[ch] != {DEC_W{1'b0}}) &&
                    (dec_cnt_q == dec_vec[ch]);
      assign gate_open = ~chan_word_q[`ACC_TRIG_EN] |
                         trig_seen_q;

      // Format selection
      always @* begin
        case (sel_vec[ch])
          `ACC_SEL_COUNT: fmt = count_q;
          `ACC_SEL_TWOS: fmt = {{(OUT_W-SAMPLE_W){dat_s3_q[SAMPLE_W-1]}},
                                dat_s3_q};
          `ACC_SEL_OFFBIN: fmt = {{(OUT_W-SAMPLE_W){1'b0}},
                                  ~dat_s3_q[SAMPLE_W-1],
                                  dat_s3_q[SAMPLE_W-2:0]};
          default: fmt = {OUT_W{1'b0}};
        endcase
      end

      always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          clk_sync_q <= 3'h0;
          clk_lvl_q <= 1'b0;
          dat_s1_q <= {SAMPLE_W{1'b0}};
          dat_s2_q <= {SAMPLE_W{1'b0}};
          dat_s3_q <= {SAMPLE_W{1'b0}};
          count_q <= {OUT_W{1'b0}};
          dec_cnt_q <= {DEC_W{1'b0}};
          sample_bus_data_q[ch*OUT_W +: OUT_W] <= {OUT_W{1'b0}};
          sample_bus_valid_q[ch] <= 1'b0;
        end else begin
          clk_sync_q <= {clk_sync_q[1:0], conv_clk_pin[ch]};
          if (clk_sync_q[1] == clk_sync_q[2]) begin
            clk_lvl_q <= clk_sync_q[2];
          end
          // Data delayed as long as the clock, so edge and word line up
          dat_s1_q <= conv_data_pin[ch*SAMPLE_W +: SAMPLE_W];
          dat_s2_q <= dat_s1_q;
          dat_s3_q <= dat_s2_q;
          sample_bus_valid_q[ch] <= 1'b0;
          if (soft_rst_q) begin
            count_q <= {OUT_W{1'b0}};
            dec_cnt_q <= {DEC_W{1'b0}};
            sample_bus_data_q[ch*OUT_W +: OUT_W] <= {OUT_W{1'b0}};
          end else if (conv_edge) begin
            count_q <= count_q + 1'b1;
            if (dec_vec[ch] == {DEC_W{1'b0}} || drop) begin
              dec_cnt_q <= {DEC_W{1'b0}};
            end else begin
              dec_cnt_q <= dec_cnt_q + 1'b1;
            end
            if (sel_vec[ch] != `ACC_SEL_OFF && !drop && gate_open) begin
              sample_bus_data_q[ch*OUT_W +: OUT_W] <= fmt;
              sample_bus_valid_q[ch] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

endmodule // acc_path_ctrl

// ==== sim/acc_path_ctrl_props.sv ====
// Checker for the converter clock and channel path control block
`timescale 1ns/1ps
module acc_path_ctrl_props (
  input wire sys_clk,
  input wire reset,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire clk_sel_first_q,
  input wire clk_sel_second_q,
  input wire clk_sel_dac_q,
  input wire clk_sel_logic_q,
  input wire [2:0] adc_synth_n_q,
  input wire [8:0] adc_synth_m_q,
  input wire [4:0] adc_synth_div_x2_q,
  input wire [2:0] dac_synth_n_q,
  input wire [8:0] dac_synth_m_q,
  input wire [4:0] dac_synth_div_x2_q,
  input wire [1:0] sample_bus_valid_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Twice the divide value, so the 1.5 step stays whole
  function automatic [4:0] x2(input [2:0] c);
    x2 = (c[0] ? 5'h3 : 5'h2) << c[2:1];
  endfunction
  wire ck_w = reg_wr && reg_wdata[31:28] == 4'h5;
  // Clock word fields land two edges after the write
  a_adc_sel: assert property (ck_w |-> ##2
    {clk_sel_first_q, clk_sel_second_q} == $past(reg_wdata[27:26], 2))
    else $error("input clock selects wrong");
  a_dac_sel: assert property (ck_w |-> ##2
    {clk_sel_dac_q, clk_sel_logic_q} == $past(reg_wdata[25:24], 2))
    else $error("output clock selects wrong");
  a_adc_synth: assert property (ck_w |-> ##2
    {adc_synth_n_q, adc_synth_m_q} == $past(reg_wdata[23:12], 2))
    else $error("input synth fields wrong");
  a_dac_synth: assert property (ck_w |-> ##2
    {dac_synth_n_q, dac_synth_m_q} == $past(reg_wdata[11:0], 2))
    else $error("output synth fields wrong");
  a_div_map: assert property (ck_w |-> ##2
    adc_synth_div_x2_q == x2($past(reg_wdata[23:21], 2)) &&
    dac_synth_div_x2_q == x2($past(reg_wdata[11:9], 2)))
    else $error("divide value wrong");
  // Quiet before, so no earlier word is still on its way out
  a_chan_tag: assert property (reg_wr && reg_wdata[31:28] == 4'h6 &&
    !$past(reg_wr) && !$past(reg_wr, 2) |->
    ##2 $stable({adc_synth_m_q, dac_synth_m_q}))
    else $error("channel word touched clock fields");
  a_soft_reset: assert property (reg_wr && reg_wdata[31:28] == 4'hd |->
    ##[2:4] clk_sel_first_q && clk_sel_dac_q && adc_synth_m_q == 9'h0 &&
    dac_synth_div_x2_q == 5'h2)
    else $error("soft reset missed clock fields");
  // Converter half periods are at least 3 cycles, so pulses are 6 apart
  a_one_edge_a: assert property (sample_bus_valid_q[0] |=>
    !sample_bus_valid_q[0] [*5]) else $error("first channel doubled");
  a_one_edge_b: assert property (sample_bus_valid_q[1] |=>
    !sample_bus_valid_q[1] [*5]) else $error("second channel doubled");
endmodule // acc_path_ctrl_props
bind acc_path_ctrl acc_path_ctrl_props acc_path_ctrl_props_i (
  .sys_clk(sys_clk), .reset(reset), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .clk_sel_first_q(clk_sel_first_q), .clk_sel_second_q(clk_sel_second_q),
  .clk_sel_dac_q(clk_sel_dac_q), .clk_sel_logic_q(clk_sel_logic_q),
  .adc_synth_n_q(adc_synth_n_q), .adc_synth_m_q(adc_synth_m_q),
  .adc_synth_div_x2_q(adc_synth_div_x2_q), .dac_synth_n_q(dac_synth_n_q),
  .dac_synth_m_q(dac_synth_m_q), .dac_synth_div_x2_q(dac_synth_div_x2_q),
  .sample_bus_valid_q(sample_bus_valid_q));

// ==== sim/acc_conv_model.sv ====
// Behavioural pair of free-running converters feeding the path control
`timescale 1ns/1ps
module acc_conv_model (
  output reg [1:0] conv_clk,
  output reg [27:0] conv_data
);
  // Edges sit off the system clock grid, 16 cycles a period
  initial begin
    conv_clk = 2'b00;
    conv_data = {14'h1ff0, 14'h3ff8};
    #3 forever #64 conv_clk[0] = ~conv_clk[0];
  end
  initial #5 forever #64 conv_clk[1] = ~conv_clk[1];
  // Data moves on the falling edge, far from the sampled rise
  always @(negedge conv_clk[0]) conv_data[13:0] <= conv_data[13:0] + 14'h0a3b;
  always @(negedge conv_clk[1]) conv_data[27:14] <= conv_data[27:14] + 14'h1357;
endmodule // acc_conv_model

// ==== sim/test_acc_path_ctrl.sv ====
// Self-checking bench for the path control block
`timescale 1ns/1ps
`include "acc_defines.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_acc_path_ctrl;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg trig = 1'b0;
  wire [31:0] rdata;
  wire [3:0] cs;
  wire [2:0] an, dn;
  wire [8:0] am, dm;
  wire [4:0] ax, dx;
  wire [1:0] ck, sv;
  wire [27:0] cd;
  wire [31:0] sd;
  integer n_errors = 0;
  integer compares = 0;
  integer i, c;
  integer nv [0:1];
  reg [2:0] sel [0:1];
  reg [15:0] last [0:1];
  reg [15:0] g;
  reg [31:0] w;
  reg [3:0] s;
  reg [39:0] t = {5'd24, 5'd16, 5'd12, 5'd8, 5'd6, 5'd4, 5'd3, 5'd2};
  always #4 sys_clk = ~sys_clk;
  acc_conv_model acc_conv_model_i (.conv_clk(ck), .conv_data(cd));
  acc_path_ctrl acc_path_ctrl_i (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .clk_sel_first_q(cs[3]),
    .clk_sel_second_q(cs[2]), .clk_sel_dac_q(cs[1]), .clk_sel_logic_q(cs[0]),
    .adc_synth_n_q(an), .adc_synth_m_q(am), .adc_synth_div_x2_q(ax),
    .dac_synth_n_q(dn), .dac_synth_m_q(dm), .dac_synth_div_x2_q(dx),
    .conv_clk_pin(ck), .conv_data_pin(cd), .ext_trigger_pin(trig),
    .sample_bus_data_q(sd), .sample_bus_valid_q(sv));
  task conclude;
    begin
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task wr(input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 `CHK("read", e, rdata)
    end
  endtask
  function [31:0] cw(input [4:0] db, da, input p, en, input [2:0] a, b);
    cw = {4'h6, 3'h0, db, 3'h0, da, 2'h0, p, en, 1'b0, a, 1'b0, b};
  endfunction
  // Checks stay off while settling, so old words are not judged
  task win(input [31:0] d, input integer e0, e1);
    begin
      sel[0] = 3'h0;
      sel[1] = 3'h0;
      wr(d);
      repeat (40) @(posedge sys_clk);
      #1 sel[0] = d[6:4];
      sel[1] = d[2:0];
      nv[0] = 0;
      nv[1] = 0;
      repeat (480) @(posedge sys_clk);
      #1 `CHK("count first", e0, nv[0])
      `CHK("count second", e1, nv[1])
      $display("test done %h", d);
    end
  endtask
  // Each delivered sample is judged: counts after the first against the last count plus one, data against its converter word
  always @(posedge sys_clk) begin
    for (c = 0; c < 2; c++) if (sv[c] === 1'b1 && sel[c] != 3'h0) begin
      nv[c]++;
      g = sd[16*c+:16];
      if (sel[c] == 3'h1) begin
        if (nv[c] > 1) `CHK("counter", last[c] + 16'h1, g)
      end else if (sel[c] == 3'h2)
        `CHK("twos", {{2{cd[14*c+13]}}, cd[14*c+:14]}, g)
      else `CHK("offset", {2'b00, ~cd[14*c+13], cd[14*c+:13]}, g)
      last[c] = g;
    end
  end
  initial begin
    #100000 n_errors++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd(4'h5, `ACC_CLOCK_RESET);
    rd(4'h6, `ACC_CHAN_RESET);
    rd(4'h3, 32'h0);
    // Fast divider codes only with external clocks, so no unsafe rate
    for (i = 0; i < 8; i++) begin
      s = {~i[2] | i[1], ~i[2] | i[0], ~i[2] | ~i[0], ~i[2] | ~i[0]};
      w = {4'h5, s, i[2:0], 9'd250 + i[8:0], i[2:0], 9'd500 - i[8:0]};
      wr(w);
      repeat (3) @(posedge sys_clk);
      #1 `CHK("clock", {s, w[23:12], t[5*i+:5], w[11:0], t[5*i+:5]}, {cs, an, am, ax, dn, dm, dx})
      rd(4'h5, w);
    end
    wr(32'h3fffffff);
    rd(4'h5, w);
    $display("test done clock word");
    win(cw(5'h2, 5'h0, 1'b0, 1'b0, `ACC_SEL_COUNT, `ACC_SEL_TWOS), 30, 20);
    win(cw(5'h0, 5'h1, 1'b0, 1'b0, `ACC_SEL_OFFBIN, `ACC_SEL_OFF), 15, 0);
    win(cw(5'h0, 5'h0, 1'b1, 1'b1, `ACC_SEL_TWOS, `ACC_SEL_OFFBIN), 0, 0);
    trig = 1'b1;
    win(cw(5'h0, 5'h0, 1'b1, 1'b1, `ACC_SEL_TWOS, `ACC_SEL_OFFBIN), 30, 30);
    win(cw(5'h0, 5'h0, 1'b0, 1'b1, `ACC_SEL_TWOS, `ACC_SEL_TWOS), 0, 0);
    trig = 1'b0;
    win(cw(5'h0, 5'h0, 1'b0, 1'b1, `ACC_SEL_TWOS, `ACC_SEL_TWOS), 30, 30);
    win(cw(5'h0, 5'h0, 1'b1, 1'b0, `ACC_SEL_TWOS, `ACC_SEL_TWOS), 30, 30);
    wr(32'hd0000000);
    repeat (4) @(posedge sys_clk);
    rd(4'h5, `ACC_CLOCK_RESET);
    rd(4'h6, `ACC_CHAN_RESET);
    $display("test done soft reset");
    conclude;
  end
endmodule // test_acc_path_ctrl
